/* File: emp_section_parser.v */
/*
 Section parser for individual-information and common message sections,
 with display timing and an AHB-Lite register slave.
 Assumes section bytes come from same-clock logic, first byte flagged.
*/
`include "emp_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module emp_section_parser #(
	parameter TENTH_MIN_CYCLES = `EMP_TENTH_MIN_CYCLES
) (
	input wire mclk,
	input wire reset,
	input wire sec_valid,
	input wire sec_start,
	input wire [7:0] sec_data,
	input wire hsel,
	input wire [31:0] haddr,
	input wire hwrite,
	input wire [1:0] htrans,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire hreadyout,
	output wire hresp,
	output wire [31:0] hrdata,
	output wire txt_valid,
	output wire [7:0] txt_data,
	output wire tamper_valid,
	output wire [7:0] tamper_data,
	output wire emm_hit,
	output wire sec_bad,
	output wire msg_show
);
	localparam D_IDLE = 2'd0;
	localparam D_T1 = 2'd1;
	localparam D_T2 = 2'd2;
	localparam D_T3 = 2'd3;

	function [31:0] emp_crc32;
		input [31:0] c;
		input [7:0] d;
		integer i;
		reg [31:0] r;
		begin
			r = c;
			for (i = 7; i >= 0; i = i - 1) begin
				if (r[31] ^ d[i])
					r = {r[30:0], 1'b0} ^ `EMP_CRC_POLY;
				else
					r = {r[30:0], 1'b0};
			end
			emp_crc32 = r;
		end
	endfunction

	function [7:0] emp_dur;
		input [1:0] st;
		input [23:0] durs;
		begin
			if (st == D_T1)
				emp_dur = durs[23:16];
			else if (st == D_T2)
				emp_dur = durs[15:8];
			else
				emp_dur = durs[7:0];
		end
	endfunction

	// Bus slave state; reads take one wait state so a write just before is seen
	reg ph_wr_ff, ph_rd_ff, rd_done_ff;
	reg [7:0] ph_addr_ff;
	reg [31:0] hrdata_ff, rd_mux;
	reg en_ff, svc_ff, dismiss_ff, crc_err_ff, len_err_ff;
	reg [47:0] card_ff;
	wire ap = hsel & htrans[1] & hready;
	wire wr_now = ph_wr_ff;

	// Section walker state
	reg [12:0] idx_ff, tot_ff, cur_idx;
	reg [3:0] len_hi_ff;
	reg act_ff;
	reg [7:0] tid_ff;
	reg [15:0] ext_ff;
	reg [4:0] ver_ff;
	reg [31:0] crc_ff, nxt_crc;
	reg [7:0] grp_ff, era_ff, d1_ff, d2_ff, d3_ff, rep_in_ff, fmt_ff;
	reg [15:0] tlen_ff;
	reg [16:0] pcnt_ff;
	reg [15:0] plen_ff, p_upd_ff, p_exp_ff, h_upd_ff, h_exp_ff;
	reg match_ff, hit_ff;
	reg txt_valid_ff, tamper_valid_ff, emm_hit_ff, sec_bad_ff;
	reg [7:0] txt_data_ff, tamper_data_ff;
	// Committed message and individual information
	reg msg_valid_ff, msg_new_ff;
	reg [15:0] m_preset_ff, m_tlen_ff, e_upd_ff, e_exp_ff;
	reg [4:0] m_ver_ff;
	reg [7:0] m_grp_ff, m_era_ff, m_d1_ff, m_d2_ff, m_d3_ff, m_rep_ff, m_fmt_ff;
	// Display sequencer
	reg [1:0] dst_ff;
	reg [7:0] tmr_ff, rep_ff;
	reg [31:0] div_ff;
	wire tick = (div_ff == TENTH_MIN_CYCLES - 1);
	wire b_ok = (cur_idx >= `EMP_HDR_LEN) && (cur_idx < tot_ff - 13'd4);
	wire last_b = (cur_idx > 13'd2) && (cur_idx == tot_ff - 13'd1);
	wire len_bad = (tid_ff == `EMP_TID_MSG) ?
		(`EMP_MSG_TXT + {1'b0, tlen_ff} != {4'h0, tot_ff} - 17'd4) : (pcnt_ff != 17'd0);

	always @* begin
		cur_idx = sec_start ? 13'd0 : idx_ff;
		nxt_crc = emp_crc32(sec_start ? 32'hFFFFFFFF : crc_ff, sec_data);
	end

	always @(posedge mclk) begin
		if (reset) begin
			ph_wr_ff <= 1'b0;
			ph_rd_ff <= 1'b0;
			rd_done_ff <= 1'b0;
			ph_addr_ff <= 8'h00;
			hrdata_ff <= 32'h00000000;
			en_ff <= `EMP_CTRL_RST;
			svc_ff <= 1'b0;
			dismiss_ff <= 1'b0;
			card_ff <= 48'h000000000000;
		end else begin
			svc_ff <= 1'b0;
			dismiss_ff <= 1'b0;
			if (ap) begin
				ph_wr_ff <= hwrite;
				ph_rd_ff <= ~hwrite;
				rd_done_ff <= 1'b0;
				ph_addr_ff <= haddr[7:0];
			end else if (hreadyout) begin
				ph_wr_ff <= 1'b0;
				ph_rd_ff <= 1'b0;
			end
			if (ph_rd_ff && !rd_done_ff) begin
				hrdata_ff <= rd_mux;
				rd_done_ff <= 1'b1;
			end
			if (wr_now) begin
				if (ph_addr_ff == `EMP_REG_CTRL) begin
					en_ff <= hwdata[`EMP_CTRL_EN];
					svc_ff <= hwdata[`EMP_CTRL_SVC];
					dismiss_ff <= hwdata[`EMP_CTRL_DISMISS];
				end else if (ph_addr_ff == `EMP_REG_CARD_LO) begin
					card_ff[31:0] <= hwdata;
				end else if (ph_addr_ff == `EMP_REG_CARD_HI) begin
					card_ff[47:32] <= hwdata[15:0];
				end
			end
		end
	end

	always @* begin
		rd_mux = 32'h00000000;
		if (ph_addr_ff == `EMP_REG_CTRL)
			rd_mux = {31'h00000000, en_ff};
		else if (ph_addr_ff == `EMP_REG_CARD_LO)
			rd_mux = card_ff[31:0];
		else if (ph_addr_ff == `EMP_REG_CARD_HI)
			rd_mux = {16'h0000, card_ff[47:32]};
		else if (ph_addr_ff == `EMP_REG_STATUS)
			rd_mux = {16'h0000, rep_ff, 2'b00, dst_ff, msg_show, msg_valid_ff,
				len_err_ff, crc_err_ff};
		else if (ph_addr_ff == `EMP_REG_MSG_ID)
			rd_mux = {3'b000, m_ver_ff, m_grp_ff, m_preset_ff};
		else if (ph_addr_ff == `EMP_REG_MSG_TIME)
			rd_mux = {m_d1_ff, m_d2_ff, m_d3_ff, m_rep_ff};
		else if (ph_addr_ff == `EMP_REG_MSG_FMT)
			rd_mux = {m_tlen_ff, m_fmt_ff, m_era_ff};
		else if (ph_addr_ff == `EMP_REG_EMM_INFO)
			rd_mux = {e_upd_ff, e_exp_ff};
	end

	always @(posedge mclk) begin
		if (reset) begin
			idx_ff <= 13'd0;
			tot_ff <= 13'd0;
			len_hi_ff <= 4'h0;
			act_ff <= 1'b0;
			tid_ff <= 8'h00;
			ext_ff <= 16'h0000;
			ver_ff <= 5'd0;
			crc_ff <= 32'hFFFFFFFF;
			{grp_ff, era_ff, d1_ff, d2_ff, d3_ff, rep_in_ff, fmt_ff} <= 56'h0;
			tlen_ff <= 16'h0000;
			pcnt_ff <= 17'd0;
			{plen_ff, p_upd_ff, p_exp_ff, h_upd_ff, h_exp_ff} <= 80'h0;
			match_ff <= 1'b0;
			hit_ff <= 1'b0;
			{txt_valid_ff, tamper_valid_ff, emm_hit_ff, sec_bad_ff} <= 4'h0;
			txt_data_ff <= 8'h00;
			tamper_data_ff <= 8'h00;
			msg_valid_ff <= 1'b0;
			msg_new_ff <= 1'b0;
			{m_preset_ff, m_tlen_ff, e_upd_ff, e_exp_ff} <= 64'h0;
			m_ver_ff <= 5'd0;
			{m_grp_ff, m_era_ff, m_d1_ff, m_d2_ff, m_d3_ff, m_rep_ff, m_fmt_ff} <= 56'h0;
			crc_err_ff <= 1'b0;
			len_err_ff <= 1'b0;
		end else begin
			{txt_valid_ff, tamper_valid_ff, emm_hit_ff, sec_bad_ff} <= 4'h0;
			msg_new_ff <= 1'b0;
			// Set wins over a same-cycle write-one-to-clear
			if (wr_now && ph_addr_ff == `EMP_REG_STATUS) begin
				if (hwdata[`EMP_ST_CRC_ERR])
					crc_err_ff <= 1'b0;
				if (hwdata[`EMP_ST_LEN_ERR])
					len_err_ff <= 1'b0;
			end
			if (sec_valid && en_ff && (sec_start || act_ff)) begin
				idx_ff <= cur_idx + 13'd1;
				crc_ff <= nxt_crc;
				if (cur_idx == 13'd0) begin
					act_ff <= (sec_data == `EMP_TID_EMM) || (sec_data == `EMP_TID_MSG);
					tid_ff <= sec_data;
					pcnt_ff <= 17'd0;
					hit_ff <= 1'b0;
				end else if (cur_idx == 13'd1)
					len_hi_ff <= sec_data[3:0];
				else if (cur_idx == 13'd2)
					tot_ff <= {1'b0, len_hi_ff, sec_data} + 13'd3;
				else if (cur_idx == 13'd3)
					ext_ff[15:8] <= sec_data;
				else if (cur_idx == 13'd4)
					ext_ff[7:0] <= sec_data;
				else if (cur_idx == 13'd5)
					ver_ff <= sec_data[5:1];
				else if (b_ok && tid_ff == `EMP_TID_MSG) begin
					// Plain text, no descrambling stage in this path
					case (cur_idx)
					13'd8: grp_ff <= sec_data;
					13'd9: era_ff <= sec_data;
					13'd10: d1_ff <= sec_data;
					13'd11: d2_ff <= sec_data;
					13'd12: d3_ff <= sec_data;
					13'd13: rep_in_ff <= sec_data;
					13'd14: fmt_ff <= sec_data;
					13'd15: tlen_ff[15:8] <= sec_data;
					13'd16: tlen_ff[7:0] <= sec_data;
					default: begin
						if ({4'h0, cur_idx} < `EMP_MSG_TXT + {1'b0, tlen_ff}) begin
							txt_valid_ff <= (era_ff != `EMP_ERA_OFF);
							txt_data_ff <= sec_data;
						end
					end
					endcase
				end else if (b_ok && tid_ff == `EMP_TID_EMM) begin
					pcnt_ff <= pcnt_ff + 17'd1;
					if (pcnt_ff < `EMP_CARD_LEN) begin
						// Card number is sent most significant byte first
						match_ff <= (pcnt_ff == 17'd0 || match_ff) &&
							(sec_data == card_ff[8 * (5 - pcnt_ff[2:0]) +: 8]);
					end else if (pcnt_ff == 17'd6)
						plen_ff[15:8] <= sec_data;
					else if (pcnt_ff == 17'd7)
						plen_ff[7:0] <= sec_data;
					else begin
						if (pcnt_ff == 17'd11)
							p_upd_ff[15:8] <= sec_data;
						if (pcnt_ff == 17'd12)
							p_upd_ff[7:0] <= sec_data;
						if (pcnt_ff == 17'd13)
							p_exp_ff[15:8] <= sec_data;
						if (pcnt_ff == 17'd14)
							p_exp_ff[7:0] <= sec_data;
						if (pcnt_ff + `EMP_TAMPER_LEN >= {1'b0, plen_ff} + 17'd8) begin
							tamper_valid_ff <= match_ff;
							tamper_data_ff <= sec_data;
						end
						if (pcnt_ff == {1'b0, plen_ff} + 17'd7) begin
							pcnt_ff <= 17'd0;
							if (match_ff) begin
								emm_hit_ff <= 1'b1;
								hit_ff <= 1'b1;
								h_upd_ff <= p_upd_ff;
								h_exp_ff <= {p_exp_ff[15:8], (pcnt_ff == 17'd14) ?
									sec_data : p_exp_ff[7:0]};
							end
						end
					end
				end
				if (last_b) begin
					act_ff <= 1'b0;
					if (nxt_crc != 32'h00000000 || len_bad) begin
						sec_bad_ff <= 1'b1;
						if (nxt_crc != 32'h00000000)
							crc_err_ff <= 1'b1;
						else
							len_err_ff <= 1'b1;
					end else if (tid_ff == `EMP_TID_MSG && ext_ff != 16'h0000) begin
						// Repeats of an unchanged message must not restart the display
						if (!msg_valid_ff || ext_ff != m_preset_ff || ver_ff != m_ver_ff)
							msg_new_ff <= 1'b1;
						msg_valid_ff <= 1'b1;
						m_preset_ff <= ext_ff;
						m_ver_ff <= ver_ff;
						m_grp_ff <= grp_ff;
						m_era_ff <= era_ff;
						{m_d1_ff, m_d2_ff, m_d3_ff} <= {d1_ff, d2_ff, d3_ff};
						{m_rep_ff, m_fmt_ff, m_tlen_ff} <= {rep_in_ff, fmt_ff, tlen_ff};
					end else if (tid_ff == `EMP_TID_EMM && hit_ff) begin
						e_upd_ff <= h_upd_ff;
						e_exp_ff <= h_exp_ff;
					end
				end
			end
		end
	end

	always @(posedge mclk) begin
		if (reset) begin
			dst_ff <= D_IDLE;
			tmr_ff <= 8'h00;
			rep_ff <= 8'h00;
			div_ff <= 32'd0;
		end else begin
			div_ff <= (tick || dst_ff == D_IDLE) ? 32'd0 : div_ff + 32'd1;
			if (msg_new_ff && m_era_ff == `EMP_ERA_OFF) begin
				dst_ff <= D_IDLE;
			end else if (dismiss_ff && m_era_ff == `EMP_ERA_FREE) begin
				dst_ff <= D_IDLE;
			end else if ((svc_ff || (msg_new_ff && dst_ff != D_IDLE)) &&
				msg_valid_ff && m_era_ff != `EMP_ERA_OFF) begin
				dst_ff <= D_T1;
				tmr_ff <= m_d1_ff;
				rep_ff <= (m_rep_ff == 8'h00) ? 8'h01 : m_rep_ff;
				div_ff <= 32'd0;
			end else if (dst_ff != D_IDLE && tmr_ff != `EMP_DUR_FOREVER) begin
				if (tmr_ff == 8'h00 || (tick && tmr_ff == 8'h01)) begin
					div_ff <= 32'd0;
					if (dst_ff != D_T3) begin
						dst_ff <= dst_ff + 2'd1;
						tmr_ff <= emp_dur(dst_ff + 2'd1, {m_d1_ff, m_d2_ff, m_d3_ff});
					end else if (rep_ff > 8'h01) begin
						dst_ff <= D_T1;
						tmr_ff <= m_d1_ff;
						rep_ff <= rep_ff - 8'h01;
					end else
						dst_ff <= D_IDLE;
				end else if (tick)
					tmr_ff <= tmr_ff - 8'h01;
			end
		end
	end

	assign hreadyout = ~ph_rd_ff | rd_done_ff;
	assign hresp = 1'b0;
	assign hrdata = hrdata_ff;
	assign txt_valid = txt_valid_ff;
	assign txt_data = txt_data_ff;
	assign tamper_valid = tamper_valid_ff;
	assign tamper_data = tamper_data_ff;
	assign emm_hit = emm_hit_ff;
	assign sec_bad = sec_bad_ff;
	// Shown in the first and third windows, blanked in the second
	assign msg_show = (dst_ff == D_T1) || (dst_ff == D_T3);
endmodule // emp_section_parser
`default_nettype wire

/* File: emp_defs.vh */
/*
 Constants for the message section parser: register offsets, field
 positions, section codes and display timing.
 Assumes a 125 MHz mclk.
*/
`ifndef EMP_DEFS_VH
`define EMP_DEFS_VH
`define EMP_REG_CTRL 8'h00
`define EMP_REG_CARD_LO 8'h04
`define EMP_REG_CARD_HI 8'h08
`define EMP_REG_STATUS 8'h0C
`define EMP_REG_MSG_ID 8'h10
`define EMP_REG_MSG_TIME 8'h14
`define EMP_REG_MSG_FMT 8'h18
`define EMP_REG_EMM_INFO 8'h1C
`define EMP_CTRL_EN 0
`define EMP_CTRL_SVC 1
`define EMP_CTRL_DISMISS 2
`define EMP_ST_CRC_ERR 0
`define EMP_ST_LEN_ERR 1
`define EMP_CTRL_RST 1'b1
`define EMP_TID_EMM 8'h84
`define EMP_TID_MSG 8'h85
`define EMP_ERA_FREE 8'h00
`define EMP_ERA_HOLD 8'h01
`define EMP_ERA_OFF 8'h02
`define EMP_DUR_FOREVER 8'hFF
`define EMP_HDR_LEN 13'd8
`define EMP_MSG_TXT 17'd17
`define EMP_CARD_LEN 17'd6
`define EMP_TAMPER_LEN 17'd32
`define EMP_CRC_POLY 32'h04C11DB7
`define EMP_TENTH_MIN_MS 6000
`define EMP_CLK_KHZ 125000
`define EMP_TENTH_MIN_CYCLES (`EMP_TENTH_MIN_MS * `EMP_CLK_KHZ)
`endif

/* File: emp_src.sv */
/*
 Section source model: streams the bytes placed in buf_b, then a CRC32 trailer.
 Assumes the bench fills buf_b and calls send right after a rising edge of mclk.
*/
`timescale 1ns/1ps
`default_nettype none
module emp_src (
	input wire logic mclk,
	output logic sec_valid,
	output logic sec_start,
	output logic [7:0] sec_data
);
	logic [7:0] buf_b [0:255];
	initial begin
		sec_valid = 1'b0;
		sec_start = 1'b0;
		sec_data = 8'h00;
	end
	// An idle cycle after every fifth byte; idle data is inverted so nothing stale looks valid
	task automatic send(input int n, input logic bad);
		logic [31:0] c;
		logic [7:0] b;
		c = 32'hFFFFFFFF;
		for (int i = 0; i < n + 4; i++) begin
			if (i < n) begin
				b = buf_b[i];
				for (int j = 7; j >= 0; j--)
					c = {c[30:0], 1'b0} ^ ((c[31] ^ b[j]) ? 32'h04C11DB7 : 32'h0);
			end else
				b = c[31 - 8 * (i - n) -: 8] ^ {7'h0, bad};
			sec_valid <= 1'b1;
			sec_start <= (i == 0);
			sec_data <= b;
			@(posedge mclk);
			if (i % 5 == 4) begin
				sec_valid <= 1'b0;
				sec_data <= ~b;
				@(posedge mclk);
			end
		end
		sec_valid <= 1'b0;
		sec_start <= 1'b0;
		sec_data <= ~b;
	endtask
endmodule // emp_src
`default_nettype wire

/* File: emp_section_parser_asserts.sv */
/*
 Checker for the section parser: bus answer timing and output pulse causes.
 Assumes it is bound to emp_section_parser and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module emp_section_parser_asserts (
	input wire logic mclk,
	input wire logic reset,
	input wire logic sec_valid,
	input wire logic hsel,
	input wire logic hwrite,
	input wire logic [1:0] htrans,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic txt_valid,
	input wire logic tamper_valid,
	input wire logic emm_hit,
	input wire logic sec_bad,
	input wire logic msg_show
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
	wire take = hsel && htrans[1] && hready;
	a_resp_okay: assert property (hresp == 1'b0) else $error("hresp not OKAY");
	a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read answer timing wrong");
	a_write_nowait: assert property (take && hwrite |=> hreadyout) else $error("write stalled");
	a_txt_cause: assert property (txt_valid |-> $past(sec_valid))
		else $error("text byte without input byte");
	a_tamper_cause: assert property (tamper_valid |-> $past(sec_valid))
		else $error("tamper byte without input byte");
	a_hit_cause: assert property (emm_hit |-> $past(sec_valid))
		else $error("card hit without input byte");
	a_bad_pulse: assert property (sec_bad |=> !sec_bad)
		else $error("error pulse too long");
	a_bad_quiet: assert property (sec_bad |-> !txt_valid && !tamper_valid && !emm_hit)
		else $error("payload output with error pulse");
	c_hit: cover property (emm_hit);
	c_bad: cover property (sec_bad);
	c_show: cover property ($rose(msg_show));
endmodule // emp_section_parser_asserts
bind emp_section_parser emp_section_parser_asserts u_chk (.mclk(mclk), .reset(reset),
	.sec_valid(sec_valid), .hsel(hsel), .hwrite(hwrite), .htrans(htrans), .hready(hready),
	.hreadyout(hreadyout), .hresp(hresp), .txt_valid(txt_valid), .tamper_valid(tamper_valid),
	.emm_hit(emm_hit), .sec_bad(sec_bad), .msg_show(msg_show));
`default_nettype wire

/* File: emp_section_parser_tb_top.sv */
/*
 Self-checking bench for the section parser: registers, messages, display, card payloads.
 Assumes the design and emp_src are compiled first; display tenth-minute shortened to 10.
*/
`include "emp_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module emp_section_parser_tb_top;
	logic mclk = 1'b0, reset = 1'b1, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, r;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h0;
	wire sec_valid, sec_start, hreadyout, hresp, txt_valid, tamper_valid, emm_hit, sec_bad, msg_show;
	wire [7:0] sec_data, txt_data, tamper_data;
	wire [31:0] hrdata;
	wire hready = hreadyout;
	int n_mismatch = 0, n_checks = 0, n_txt = 0, n_tmp = 0, n_hit = 0, n_bad = 0, tk, tp;
	always #4 mclk = ~mclk;
	emp_src u_src (.mclk(mclk), .sec_valid(sec_valid), .sec_start(sec_start), .sec_data(sec_data));
	emp_section_parser #(.TENTH_MIN_CYCLES(10)) u_dut (.mclk(mclk), .reset(reset),
		.sec_valid(sec_valid), .sec_start(sec_start), .sec_data(sec_data), .hsel(hsel),
		.haddr(haddr), .hwrite(hwrite), .htrans(htrans), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.txt_valid(txt_valid), .txt_data(txt_data), .tamper_valid(tamper_valid),
		.tamper_data(tamper_data), .emm_hit(emm_hit), .sec_bad(sec_bad), .msg_show(msg_show));
	task report_and_stop;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	// Text and tamper bytes carry position patterns, so order and count are both seen
	always @(posedge mclk) begin
		if (sec_valid && sec_start) begin
			tk = 0;
			tp = 0;
		end
		if (txt_valid) begin
			chk(txt_data, 8'hA0 + 8'(tk));
			tk++;
			n_txt++;
		end
		if (tamper_valid) begin
			chk(tamper_data, 8'h30 + 8'(tp));
			tp++;
			n_tmp++;
		end
		n_hit += emm_hit;
		n_bad += sec_bad;
	end
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		int k;
		k = 0;
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		hsize <= 3'h2;
		@(posedge mclk);
		while (hready !== 1'b1 && k < 50) begin
			k++;
			@(posedge mclk);
		end
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge mclk);
		while (hready !== 1'b1 && k < 50) begin
			k++;
			@(posedge mclk);
		end
		r = hrdata;
		if (k >= 50) begin
			n_mismatch++;
			report_and_stop;
		end
	endtask
	task automatic hdr(input logic [7:0] tid, input logic [15:0] ext, input logic [4:0] v,
		input int body);
		logic [63:0] f;
		f = {tid, 4'hB, 12'(body + 9), ext, 2'h3, v, 1'b1, 16'h0};
		for (int k = 0; k < 8; k++)
			u_src.buf_b[k] = f[63 - 8 * k -: 8];
	endtask
	task automatic msg(input logic [15:0] ext, input logic [4:0] v,
		input logic [39:0] tim, input int n, input logic bad);
		logic [71:0] f;
		f = {8'h5A, tim, 8'h03, 16'(n)};
		hdr(`EMP_TID_MSG, ext, v, 9 + n);
		for (int k = 0; k < 9; k++)
			u_src.buf_b[8 + k] = f[71 - 8 * k -: 8];
		for (int k = 0; k < n; k++)
			u_src.buf_b[17 + k] = 8'hA0 + 8'(k);
		u_src.send(17 + n, bad);
		repeat (3) @(posedge mclk);
	endtask
	task automatic pay(input int b, input logic [47:0] card, input logic [15:0] upd);
		logic [119:0] f;
		f = {card, 16'd39, 8'h01, 16'h005A, upd, 16'h1234};
		for (int k = 0; k < 15; k++)
			u_src.buf_b[b + k] = f[119 - 8 * k -: 8];
		for (int k = 0; k < 32; k++)
			u_src.buf_b[b + 15 + k] = 8'h30 + 8'(k);
	endtask
	task t_regs;
		ahb(0, `EMP_REG_CTRL, 0);
		chk(r[0], 1'b1);
		ahb(1, 8'h20, 32'hFFFFFFFF);
		ahb(0, 8'h20, 0);
		chk(r, 0);
		ahb(1, `EMP_REG_CARD_LO, 32'h56789ABC);
		ahb(1, `EMP_REG_CARD_HI, 32'h00001234);
		ahb(0, `EMP_REG_CARD_HI, 0);
		chk(r, 32'h00001234);
	endtask
	task t_msg;
		msg(16'h0102, 5'd1, {8'h01, 8'd2, 8'd1, 8'd2, 8'd2}, 5, 0);
		chk(n_txt, 5);
		ahb(0, `EMP_REG_MSG_ID, 0);
		chk(r, {3'h0, 5'd1, 8'h5A, 16'h0102});
		ahb(0, `EMP_REG_MSG_TIME, 0);
		chk(r, {8'd2, 8'd1, 8'd2, 8'd2});
		ahb(0, `EMP_REG_MSG_FMT, 0);
		chk(r, {16'd5, 8'h03, 8'h01});
	endtask
	// Two passes of 20 shown, 10 blank, 20 shown cycles; start edge tolerance of two
	task t_timing;
		int hi;
		hi = 0;
		ahb(1, `EMP_REG_CTRL, 32'h3);
		repeat (300) begin
			@(posedge mclk);
			hi += msg_show;
		end
		chk(hi >= 78 && hi <= 82, 1);
		ahb(0, `EMP_REG_STATUS, 0);
		chk(r[5:4], 2'h0);
	endtask
	task t_crc;
		msg(16'h0777, 5'd2, 40'h0101010101, 2, 1);
		chk(n_bad, 1);
		ahb(0, `EMP_REG_STATUS, 0);
		chk(r[0], 1'b1);
		ahb(0, `EMP_REG_MSG_ID, 0);
		chk(r[15:0], 16'h0102);
		ahb(1, `EMP_REG_STATUS, 32'h1);
		ahb(0, `EMP_REG_STATUS, 0);
		chk(r[0], 1'b0);
		// Text length that cannot fit the section; erasure 0x02 keeps text off the stream
		hdr(`EMP_TID_MSG, 16'h0900, 5'd6, 11);
		for (int k = 0; k < 11; k++)
			u_src.buf_b[8 + k] = 8'h02;
		u_src.send(19, 0);
		repeat (3) @(posedge mclk);
		chk(n_bad, 2);
		ahb(0, `EMP_REG_STATUS, 0);
		chk(r[1:0], 2'h2);
	endtask
	task t_hold;
		msg(16'h0102, 5'd3, {8'h01, 32'hFF010101}, 2, 0);
		ahb(1, `EMP_REG_CTRL, 32'h3);
		repeat (100) @(posedge mclk);
		chk(msg_show, 1'b1);
		ahb(1, `EMP_REG_CTRL, 32'h5);
		repeat (2) @(posedge mclk);
		chk(msg_show, 1'b1);
		msg(16'h0102, 5'd4, {8'h00, 32'hFF010101}, 2, 0);
		chk(msg_show, 1'b1);
		ahb(1, `EMP_REG_CTRL, 32'h5);
		ahb(0, `EMP_REG_STATUS, 0);
		chk(msg_show, 1'b0);
		ahb(1, `EMP_REG_CTRL, 32'h3);
		ahb(0, `EMP_REG_STATUS, 0);
		chk(msg_show, 1'b1);
		msg(16'h0102, 5'd5, {8'h02, 32'hFF010101}, 3, 0);
		chk(n_txt, 11);
		chk(msg_show, 1'b0);
		ahb(1, `EMP_REG_CTRL, 32'h3);
		ahb(0, `EMP_REG_STATUS, 0);
		chk(msg_show, 1'b0);
	endtask
	task t_emm;
		hdr(`EMP_TID_EMM, 16'h0001, 5'd0, 94);
		pay(8, 48'h123456789ABD, 16'h0011);
		pay(55, 48'h123456789ABC, 16'h0042);
		u_src.send(102, 0);
		repeat (3) @(posedge mclk);
		chk(n_hit, 1);
		chk(n_tmp, 32);
		ahb(0, `EMP_REG_EMM_INFO, 0);
		chk(r, {16'h0042, 16'h1234});
	endtask
	initial begin
		repeat (2) @(posedge mclk);
		reset <= 1'b0;
		@(posedge mclk);
		t_regs;
		t_msg;
		t_timing;
		t_crc;
		t_hold;
		t_emm;
		report_and_stop;
	end
endmodule // emp_section_parser_tb_top
`default_nettype wire
